// ---- rtl/acf_pkg.sv ----
// shared constants and carrier types of the adaptive comb filter core
package acf_pkg;
	localparam int DW = 10;
	localparam int EW = 8;
	localparam int LUT_N = 256;
	localparam int LUT_AW = 8;
	localparam int LUT_DW = 5;
	localparam int K_SHIFT = 5;
	// architecture select codes
	localparam logic [3:0] ARCH_3L = 4'h0;
	localparam logic [3:0] ARCH_3L_LO = 4'h1;
	localparam logic [3:0] ARCH_3L_UP = 4'h2;
	localparam logic [3:0] ARCH_2L_LO = 4'h3;
	localparam logic [3:0] ARCH_FLD2 = 4'h4;
	localparam logic [3:0] ARCH_FLD = 4'h5;
	localparam logic [3:0] ARCH_FRM2 = 4'h6;
	localparam logic [3:0] ARCH_FRM = 4'h7;
	localparam logic [3:0] ARCH_D1_3L = 4'h8;
	localparam logic [3:0] ARCH_D1_LO = 4'h9;
	localparam logic [3:0] ARCH_D1_UP = 4'ha;
	localparam logic [3:0] ARCH_D1_OUT = 4'hb;
	localparam logic [3:0] ARCH_D1_FLD2 = 4'hc;
	localparam logic [3:0] ARCH_D1_2L = 4'hd;
	localparam logic [3:0] ARCH_D1_FRM2 = 4'he;
	localparam logic [3:0] ARCH_D1_FRM = 4'hf;
	// error level above which a tap pair counts as different
	localparam logic [EW-1:0] FAIL_THR = 8'h08;
	// lookup outputs and cross-fade controls
	localparam logic [LUT_DW-1:0] LUT_RST = 5'h1f;
	localparam logic [LUT_DW-1:0] LUT_FULL = 5'h1f;
	localparam logic [LUT_DW-1:0] LUT_NONE = 5'h01;
	localparam logic [LUT_DW-1:0] LUT_SPEC = 5'h00;
	localparam logic [5:0] K_FULL = 6'h20;
	localparam logic [5:0] K_NONE = 6'h00;

	typedef enum logic [1:0] {
		AM_BEST3 = 2'b00,
		AM_LOWER = 2'b01,
		AM_FIXED = 2'b10,
		AM_PAL3 = 2'b11
	} acf_adapt_t;

	typedef enum logic [1:0] {SEL_3L, SEL_UP, SEL_LO, SEL_OUTER} acf_sel_t;

	typedef struct packed {
		logic signed [DW-1:0] full;
		logic signed [DW-1:0] lo;
		logic [EW-1:0] hue;
		logic [EW-1:0] sat;
	} acf_tap_t;

	typedef struct packed {
		logic [EW-1:0] luma;
		logic [EW-1:0] sat;
		logic [EW-1:0] hue;
	} acf_err_t;

	typedef struct packed {
		logic signed [DW-1:0] data;
		acf_sel_t sel;
		logic [EW+1:0] err_mag;
		logic arch_change;
		logic half_line;
	} acf_word_t;

	typedef struct packed {
		logic v;
		acf_tap_t t0;
		acf_tap_t t1;
		acf_tap_t t2;
		logic signed [DW-1:0] simple_lo;
		logic signed [DW-1:0] simple_hi;
		acf_err_t up;
		acf_err_t lo;
	} acf_s1_t;

	typedef struct packed {
		logic v;
		logic signed [DW-1:0] f0;
		logic signed [DW-1:0] f1;
		logic signed [DW-1:0] f2;
		logic signed [DW-1:0] simple_lo;
		logic signed [DW-1:0] simple_hi;
		acf_sel_t sel;
		logic [LUT_AW-1:0] addr;
		logic [EW+1:0] err_mag;
		logic arch_change;
	} acf_s2_t;

	typedef struct packed {
		acf_s1_t s1;
		acf_s2_t s2;
		acf_sel_t sel;
		acf_sel_t raw;
		logic [LUT_N-1:0][LUT_DW-1:0] lut;
	} acf_st_t;

	typedef struct packed {
		acf_word_t head;
		logic head_v;
		acf_word_t skid;
		logic skid_v;
		logic ready;
	} acf_buf_t;
endpackage

// ---- rtl/acf_skid_buf.sv ----
// two-entry output buffer of the comb filter core
`timescale 1ns/10ps
module acf_skid_buf import acf_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input acf_word_t in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output acf_word_t out_data_o
);
	acf_buf_t st_q;
	acf_buf_t st_d;
	logic push;
	logic take;

	always_comb begin
		st_d = st_q;
		push = in_valid_i && st_q.ready;
		take = !st_q.head_v || out_ready_i;
		if (take) begin
			if (st_q.skid_v) begin
				st_d.head = st_q.skid;
				st_d.head_v = 1'b1;
				st_d.skid = in_data_i;
				st_d.skid_v = push;
			end else begin
				st_d.head = in_data_i;
				st_d.head_v = push;
				st_d.skid_v = 1'b0;
			end
		end else if (push) begin
			st_d.skid = in_data_i;
			st_d.skid_v = 1'b1;
		end
		// ready from a flop so the stall reaches the source cleanly
		st_d.ready = !st_d.skid_v;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= '0;
			st_q.ready <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign in_ready_o = st_q.ready;
	assign out_valid_o = st_q.head_v;
	assign out_data_o = st_q.head;
endmodule

// ---- rtl/acf_core.sv ----
// adaptive three-line comb filter core with cross-fade to bandsplit
`timescale 1ns/10ps
module acf_core import acf_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// configuration
	input wire logic [3:0] architecture_select_i,
	input acf_adapt_t adapt_mode_i,
	input wire logic unfiltered_sel_i,
	input wire logic luma_comb_i,
	// mix lookup table write port
	input wire logic lut_we_i,
	input wire logic [LUT_AW-1:0] lut_addr_i,
	input wire logic [LUT_DW-1:0] lut_data_i,
	// sample input
	input wire logic in_valid_i,
	output logic in_ready_o,
	input acf_tap_t undelayed_tap_i,
	input acf_tap_t first_delayed_tap_i,
	input acf_tap_t second_delayed_tap_i,
	input wire logic signed [DW-1:0] simple_lo_i,
	input wire logic signed [DW-1:0] simple_hi_i,
	// combed output
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic signed [DW-1:0] combed_output_o,
	output acf_sel_t comb_sel_o,
	output logic [EW+1:0] error_mag_o,
	output logic arch_change_o,
	output logic half_line_o
);
	acf_st_t st_q;
	acf_st_t st_d;
	logic adv;
	logic up_f;
	logic lo_f;
	logic adaptive;
	logic force_sel;
	acf_sel_t raw;
	acf_sel_t sel;
	acf_err_t eset;
	logic [EW+1:0] up_sum;
	logic [EW+1:0] lo_sum;
	logic signed [DW+2:0] e0;
	logic signed [DW+2:0] e1;
	logic signed [DW+2:0] e2;
	logic signed [DW+2:0] hf;
	logic [LUT_DW-1:0] lut_out;
	logic [5:0] k;
	logic signed [DW+9:0] prod;
	logic signed [DW+9:0] scaled;
	logic signed [DW+9:0] mixed;
	acf_word_t word;
	acf_word_t buf_word;
	logic buf_ready;

	function automatic logic [EW-1:0] lvl_err(
		input logic signed [DW-1:0] a,
		input logic signed [DW-1:0] b
	);
		logic signed [DW:0] d;
		logic [DW:0] m;
		d = {a[DW-1], a} - {b[DW-1], b};
		m = d[DW] ? (DW+1)'(-d) : d;
		return (|m[DW:EW]) ? {EW{1'b1}} : m[EW-1:0];
	endfunction

	// phase wraps, so the shorter way round is the error
	function automatic logic [EW-1:0] hue_err(
		input logic [EW-1:0] a,
		input logic [EW-1:0] b
	);
		logic [EW-1:0] d;
		d = a - b;
		return d[EW-1] ? EW'(-d) : d;
	endfunction

	function automatic logic [EW+1:0] err_sum(input acf_err_t e);
		return {2'b00, e.luma} + {2'b00, e.sat} + {2'b00, e.hue};
	endfunction

	function automatic logic signed [DW-1:0] sat_dw(
		input logic signed [DW+9:0] v
	);
		logic signed [DW+9:0] hi;
		logic signed [DW+9:0] lo;
		hi = (DW+10)'(2 ** (DW - 1) - 1);
		lo = -(DW+10)'(2 ** (DW - 1));
		return (v > hi) ? hi[DW-1:0] : ((v < lo) ? lo[DW-1:0] :
			v[DW-1:0]);
	endfunction

	always_comb begin
		st_d = st_q;
		adv = buf_ready;
		if (lut_we_i) begin
			st_d.lut[lut_addr_i] = lut_data_i;
		end
		up_sum = err_sum(st_q.s1.up);
		lo_sum = err_sum(st_q.s1.lo);
		up_f = (st_q.s1.up.luma > FAIL_THR) || (st_q.s1.up.sat > FAIL_THR) ||
			(st_q.s1.up.hue > FAIL_THR);
		lo_f = (st_q.s1.lo.luma > FAIL_THR) || (st_q.s1.lo.sat > FAIL_THR) ||
			(st_q.s1.lo.hue > FAIL_THR);
		raw = SEL_3L;
		adaptive = 1'b0;
		case (architecture_select_i)
			ARCH_3L, ARCH_FLD, ARCH_FRM, ARCH_D1_3L, ARCH_D1_FRM: begin
				adaptive = (adapt_mode_i != AM_FIXED);
				case (adapt_mode_i)
					AM_BEST3: raw = (lo_f && !up_f) ? SEL_UP :
						((up_f && !lo_f) ? SEL_LO : SEL_3L);
					AM_LOWER: raw = (lo_f || up_f) ? SEL_LO : SEL_3L;
					AM_PAL3: raw = lo_f ? SEL_OUTER : SEL_3L;
					AM_FIXED: raw = SEL_3L;
					default: raw = SEL_3L;
				endcase
			end
			// restricted fallback to the lower pair
			ARCH_3L_LO, ARCH_D1_LO: begin
				adaptive = (adapt_mode_i != AM_FIXED);
				raw = (adaptive && (lo_f || up_f)) ? SEL_LO : SEL_3L;
			end
			// restricted fallback to the upper pair
			ARCH_3L_UP, ARCH_D1_UP: begin
				adaptive = (adapt_mode_i != AM_FIXED);
				raw = (adaptive && (lo_f || up_f)) ? SEL_UP : SEL_3L;
			end
			ARCH_D1_OUT: raw = SEL_OUTER;
			// two-line combs ignore the adaption mode
			default: raw = SEL_LO;
		endcase
		force_sel = !adaptive;
		// filtered selection needs two equal decisions
		sel = (unfiltered_sel_i || force_sel || (raw == st_q.raw)) ?
			raw : st_q.sel;
		// larger set drives the lookup on a three-line comb
		case (sel)
			SEL_UP: eset = st_q.s1.up;
			SEL_LO: eset = st_q.s1.lo;
			SEL_OUTER: eset = st_q.s1.lo;
			default: eset = (up_sum > lo_sum) ? st_q.s1.up : st_q.s1.lo;
		endcase
		// stage 3: comb, lookup and cross-fade from stage 2
		e0 = (DW+3)'(st_q.s2.f0);
		e1 = (DW+3)'(st_q.s2.f1);
		e2 = (DW+3)'(st_q.s2.f2);
		case (st_q.s2.sel)
			SEL_UP: hf = (e1 + e2) >>> 1;
			SEL_LO: hf = (e0 + e1) >>> 1;
			SEL_OUTER: hf = (e0 + e2) >>> 1;
			default: hf = (e0 + (e1 <<< 1) + e2) >>> 2;
		endcase
		lut_out = st_q.lut[st_q.s2.addr];
		if (lut_out == LUT_FULL) begin
			k = K_FULL;
		end else if (lut_out == LUT_NONE) begin
			k = K_NONE;
		end else if (lut_out == LUT_SPEC) begin
			// special: luma combs fully, chroma stays bandsplit
			k = luma_comb_i ? K_FULL : K_NONE;
		end else begin
			k = {1'b0, lut_out};
		end
		prod = $signed({1'b0, k}) * hf;
		scaled = prod >>> K_SHIFT;
		// add for luma, subtract for chroma
		mixed = luma_comb_i ? (DW+10)'(st_q.s2.simple_lo) + scaled :
			(DW+10)'(st_q.s2.simple_hi) - scaled;
		word.data = sat_dw(mixed);
		word.sel = st_q.s2.sel;
		word.err_mag = st_q.s2.err_mag;
		word.arch_change = st_q.s2.arch_change;
		word.half_line = (st_q.s2.sel == SEL_UP) || (st_q.s2.sel == SEL_LO);
		if (adv) begin
			st_d.s1.v = in_valid_i;
			st_d.s1.t0 = undelayed_tap_i;
			st_d.s1.t1 = first_delayed_tap_i;
			st_d.s1.t2 = second_delayed_tap_i;
			st_d.s1.simple_lo = simple_lo_i;
			st_d.s1.simple_hi = simple_hi_i;
			// upper: two stores, lower: input and first
			st_d.s1.up.luma = lvl_err(first_delayed_tap_i.lo,
				second_delayed_tap_i.lo);
			st_d.s1.up.sat = lvl_err(DW'(first_delayed_tap_i.sat),
				DW'(second_delayed_tap_i.sat));
			st_d.s1.up.hue = hue_err(first_delayed_tap_i.hue,
				second_delayed_tap_i.hue);
			st_d.s1.lo.luma = lvl_err(undelayed_tap_i.lo,
				first_delayed_tap_i.lo);
			st_d.s1.lo.sat = lvl_err(DW'(undelayed_tap_i.sat),
				DW'(first_delayed_tap_i.sat));
			st_d.s1.lo.hue = hue_err(undelayed_tap_i.hue,
				first_delayed_tap_i.hue);
			st_d.s2.v = st_q.s1.v;
			st_d.s2.f0 = st_q.s1.t0.full;
			st_d.s2.f1 = st_q.s1.t1.full;
			st_d.s2.f2 = st_q.s1.t2.full;
			st_d.s2.simple_lo = st_q.s1.simple_lo;
			st_d.s2.simple_hi = st_q.s1.simple_hi;
			st_d.s2.sel = sel;
			st_d.s2.addr = {eset.hue[EW-1 -: 2], eset.sat[EW-1 -: 3],
				eset.luma[EW-1 -: 3]};
			// fail reports magnitude and comb change
			st_d.s2.err_mag = err_sum(eset);
			st_d.s2.arch_change = adaptive && (lo_f || up_f);
			if (st_q.s1.v) begin
				st_d.sel = sel;
				st_d.raw = raw;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= '0;
			st_q.lut <= {LUT_N{LUT_RST}};
		end else begin
			st_q <= st_d;
		end
	end

	// stall from here freezes every stage, so no word is lost
	acf_skid_buf u_buf (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.in_valid_i(adv && st_q.s2.v),
		.in_ready_o(buf_ready),
		.in_data_i(word),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o(buf_word)
	);
	assign in_ready_o = buf_ready;
	assign combed_output_o = buf_word.data;
	assign comb_sel_o = buf_word.sel;
	assign error_mag_o = buf_word.err_mag;
	assign arch_change_o = buf_word.arch_change;
	assign half_line_o = buf_word.half_line;

	AST_TWO_LINE_FIXED: assert property (@(posedge clk_i)
		disable iff (!arst_n_i)
		(adv && st_q.s1.v && architecture_select_i == ARCH_2L_LO)
		|=> (st_q.s2.sel == SEL_LO))
		else $error("code 3 did not select lower pair");

	AST_FIELD_FIXED: assert property (@(posedge clk_i)
		disable iff (!arst_n_i)
		(adv && st_q.s1.v && architecture_select_i == ARCH_FLD &&
		adapt_mode_i == AM_FIXED) |=> (st_q.s2.sel == SEL_3L))
		else $error("field comb not three-line");

	AST_D1_OUTER: assert property (@(posedge clk_i)
		disable iff (!arst_n_i)
		(adv && st_q.s1.v && architecture_select_i == ARCH_D1_OUT)
		|=> (st_q.s2.sel == SEL_OUTER && !st_q.s2.arch_change))
		else $error("code 11 not outer comb");

	AST_TAP_ORDER: assert property (@(posedge clk_i)
		disable iff (!arst_n_i)
		(in_valid_i && adv) |=> (st_q.s1.v &&
		st_q.s1.t0 == $past(undelayed_tap_i) &&
		st_q.s1.t2 == $past(second_delayed_tap_i)))
		else $error("taps not captured in order");

	AST_FIXED_MODE: assert property (@(posedge clk_i)
		disable iff (!arst_n_i)
		(adv && st_q.s1.v && architecture_select_i == ARCH_3L &&
		adapt_mode_i == AM_FIXED) |=> (st_q.s2.sel == SEL_3L &&
		!st_q.s2.arch_change))
		else $error("fixed mode still adapted");

	AST_CLOSEST_PAIR: assert property (@(posedge clk_i)
		disable iff (!arst_n_i)
		(adv && st_q.s1.v && architecture_select_i == ARCH_3L &&
		adapt_mode_i == AM_BEST3 && unfiltered_sel_i && lo_f && !up_f)
		|=> (st_q.s2.sel == SEL_UP && st_q.s2.arch_change))
		else $error("did not drop differing undelayed tap");

	AST_FILTER_HOLD: assert property (@(posedge clk_i)
		disable iff (!arst_n_i)
		(adv && st_q.s1.v && !unfiltered_sel_i && !force_sel &&
		raw != st_q.raw) |=> (st_q.s2.sel == $past(st_q.sel)))
		else $error("filtered selection changed early");

	AST_OUT_HOLD: assert property (@(posedge clk_i)
		disable iff (!arst_n_i)
		(out_valid_o && !out_ready_i) |=> (out_valid_o &&
		$stable(combed_output_o) && $stable(comb_sel_o)))
		else $error("stalled output word changed");
endmodule

// ---- testbench/acf_src_model.sv ----
// source model: line stores and bandsplit feeding the comb core
`timescale 1ns/10ps
module acf_src_model import acf_pkg::*; (
	// clock
	input wire logic clk_i,
	// sample stream towards the core
	output logic in_valid_o,
	input wire logic in_ready_i,
	output acf_tap_t t0_o,
	output acf_tap_t t1_o,
	output acf_tap_t t2_o,
	output logic signed [DW-1:0] lo_o,
	output logic signed [DW-1:0] hi_o
);
	localparam int W = 3 * $bits(acf_tap_t) + 2 * DW;
	logic [W-1:0] q[$];
	logic acc_q = 1'b0;
	// slow source leaves an idle cycle after each sample
	logic slow = 1'b0;
	initial begin
		in_valid_o = 1'b0;
		{t0_o, t1_o, t2_o, lo_o, hi_o} = '0;
	end
	always @(posedge clk_i) acc_q <= in_valid_o && in_ready_i;
	// taps and aligned bandsplit held until taken
	always @(negedge clk_i) begin
		if (!in_valid_o || acc_q) begin
			if (q.size() > 0 && !(slow && in_valid_o)) begin
				in_valid_o = 1'b1;
				{t0_o, t1_o, t2_o, lo_o, hi_o} = q.pop_front();
			end else begin
				// idle lines toggle so stale data never looks valid
				in_valid_o = 1'b0;
				{t0_o, t1_o, t2_o, lo_o, hi_o} = ~{t0_o, t1_o, t2_o, lo_o, hi_o};
			end
		end
	end
	task automatic push(input logic [W-1:0] d);
		q.push_back(d);
	endtask
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench of the adaptive comb filter core
`timescale 1ns/10ps
module testbench import acf_pkg::*;;
	localparam logic [31:0] sel_tbl = 32'h6ad96699;
	localparam int ko[6] = '{1, 16, 30, 0, 31, 0};
	localparam int kk[6] = '{0, 16, 30, 32, 32, 0};
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [3:0] arch = 4'h0;
	acf_adapt_t mode = AM_BEST3;
	logic unf = 1'b1;
	logic lc = 1'b1;
	logic we = 1'b0;
	logic [LUT_AW-1:0] wa = '0;
	logic [LUT_DW-1:0] wd = '0;
	logic in_valid, in_ready, out_valid, ach, hl;
	logic out_ready = 1'b1;
	acf_tap_t t0, t1, t2;
	logic signed [DW-1:0] lo, hi, comb;
	acf_sel_t sel;
	logic [EW+1:0] emag;
	int n_errors = 0;
	int n_tests = 0;
	int rmode = 0;
	logic [31:0] sr = 32'ha7b501fb;
	logic [31:0] sd = 32'ha7b501fb;
	acf_word_t expq[$];
	bit fq[$];
	acf_word_t w;
	bit f;
	always #12.5 clk_i = ~clk_i;
	acf_src_model acf_src_model_i (.clk_i(clk_i), .in_valid_o(in_valid),
		.in_ready_i(in_ready), .t0_o(t0), .t1_o(t1), .t2_o(t2),
		.lo_o(lo), .hi_o(hi));
	acf_core acf_core_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.architecture_select_i(arch), .adapt_mode_i(mode),
		.unfiltered_sel_i(unf), .luma_comb_i(lc), .lut_we_i(we),
		.lut_addr_i(wa), .lut_data_i(wd), .in_valid_i(in_valid),
		.in_ready_o(in_ready), .undelayed_tap_i(t0),
		.first_delayed_tap_i(t1), .second_delayed_tap_i(t2),
		.simple_lo_i(lo), .simple_hi_i(hi), .out_valid_o(out_valid),
		.out_ready_i(out_ready), .combed_output_o(comb),
		.comb_sel_o(sel), .error_mag_o(emag), .arch_change_o(ach),
		.half_line_o(hl));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic acf_tap_t mk(input int v);
		mk.full = v[DW-1:0];
		mk.lo = v[DW-1:0];
		mk.hue = 8'h10;
		mk.sat = 8'h20;
	endfunction
	task automatic check(input string nm, input logic [9:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic px(input int f0, f1, f2, l, h, k, e,
		input acf_sel_t s, input bit ac, c);
		int hf;
		int o;
		acf_word_t x;
		case (s)
			SEL_3L: hf = (f0 + 2 * f1 + f2) >>> 2;
			SEL_UP: hf = (f1 + f2) >>> 1;
			SEL_LO: hf = (f0 + f1) >>> 1;
			default: hf = (f0 + f2) >>> 1;
		endcase
		o = lc ? l + ((k * hf) >>> 5) : h - ((k * hf) >>> 5);
		o = (o > 511) ? 511 : (o < -512) ? -512 : o;
		x = '0;
		x.data = o[DW-1:0];
		x.sel = s;
		x.err_mag = e[EW+1:0];
		x.arch_change = ac;
		x.half_line = (s == SEL_UP) || (s == SEL_LO);
		expq.push_back(x);
		fq.push_back(c);
		acf_src_model_i.push({mk(f0), mk(f1), mk(f2), l[DW-1:0], h[DW-1:0]});
	endtask
	task automatic lut_wr(input int a, d);
		we = 1'b1;
		wa = a[LUT_AW-1:0];
		wd = d[LUT_DW-1:0];
		@(negedge clk_i);
		we = 1'b0;
	endtask
	task automatic drain;
		for (int i = 0; i < 400 && expq.size() > 0; i++)
			@(posedge clk_i);
		if (expq.size() > 0) begin
			n_errors++;
			$display("wrong value drain expected 0 seen %0d", expq.size());
			wrap_up();
		end
		@(negedge clk_i);
	endtask
	// receiver stalls as the mode asks
	always @(negedge clk_i) begin
		sr = lfsr(sr);
		out_ready = (rmode == 2) ? sr[3] : (rmode == 0);
	end
	always @(posedge clk_i) begin
		if (out_valid && out_ready) begin
			if (expq.size() == 0) begin
				n_errors++;
				$display("wrong value extra_word expected 0 seen 1");
			end else begin
				w = expq.pop_front();
				f = fq.pop_front();
				check("combed_output", comb, w.data);
				check("comb_sel", {8'h0, sel}, {8'h0, w.sel});
				check("half_line", {9'h0, hl}, {9'h0, w.half_line});
				if (f) begin
					check("error_mag", emag, w.err_mag);
					check("arch_change", {9'h0, ach}, {9'h0, w.arch_change});
				end
			end
		end
	end
	initial begin
		int v;
		repeat (20) @(posedge clk_i);
		@(negedge clk_i);
		arst_n_i = 1'b1;
		@(negedge clk_i);
		px(40, 40, 40, 20, -15, 32, 0, SEL_3L, 0, 1);
		drain();
		lc = 1'b0;
		px(40, 40, 40, 20, -15, 32, 0, SEL_3L, 0, 1);
		drain();
		lc = 1'b1;
		px(100, 40, 40, 20, -15, 32, 0, SEL_UP, 1, 1);
		px(40, 40, 100, 20, -15, 32, 0, SEL_LO, 1, 1);
		px(0, 40, 100, 20, -15, 32, 60, SEL_3L, 1, 1);
		drain();
		for (int m = 1; m < 4; m++) begin
			mode = acf_adapt_t'(m);
			px(100, 40, 40, 20, -15, 32, 60,
				(m == 1) ? SEL_LO : (m == 2) ? SEL_3L : SEL_OUTER, m != 2, 1);
			drain();
		end
		mode = AM_BEST3;
		// filtered choice follows only a repeated decision
		unf = 1'b0;
		for (int i = 0; i < 4; i++)
			px(i < 2 ? 40 : 100, 40, 40, 20, -15, 32, i == 2 ? 60 : 0,
				i == 3 ? SEL_UP : (i == 0 ? SEL_OUTER : SEL_3L), i > 1, 1);
		drain();
		unf = 1'b1;
		for (int a = 0; a < 16; a++) begin
			arch = a[3:0];
			px(100, 40, 40, 20, -15, 32, 0, acf_sel_t'(sel_tbl[2*a+:2]), 0, 0);
			drain();
			if (a == 5) begin
				mode = AM_FIXED;
				px(100, 40, 40, 20, -15, 32, 60, SEL_3L, 0, 1);
				drain();
				mode = AM_BEST3;
			end
		end
		arch = ARCH_3L;
		for (int i = 0; i < 6; i++) begin
			lc = i < 5;
			lut_wr(0, ko[i]);
			px(40, 40, 40, 20, -15, kk[i], 0, SEL_3L, 0, 0);
			drain();
		end
		lc = 1'b1;
		lut_wr(0, 31);
		// full stall must refuse input, then random stalls lose nothing
		rmode = 1;
		for (int i = 0; i < 6; i++)
			px(40, 40, 40, i, -i, 32, 0, SEL_3L, 0, 1);
		repeat (12) @(negedge clk_i);
		check("in_ready", {9'h0, in_ready}, 10'h0);
		rmode = 2;
		for (int i = 0; i < 40; i++) begin
			sd = lfsr(sd);
			acf_src_model_i.slow = sd[9];
			v = int'(sd[6:0]) - 64;
			px(v, v, v, int'(sd[15:8]) - 128, int'(sd[23:16]) - 128,
				32, 0, SEL_3L, 0, 1);
			@(negedge clk_i);
		end
		drain();
		rmode = 0;
		wrap_up();
	end
endmodule
